// ==== rtl/sqx_pkg.sv ====
package sqx_pkg;
	// Engine sizes
	localparam int N_IN = 10;
	localparam int N_SEL = 11;
	localparam int N_OUT = 10;
	localparam int N_STATES = 63;
	localparam logic [3:0] WARN_IDX = 4'hA;
	// Input positions used by the example program
	localparam logic [3:0] IN_MAIN = 4'h0;
	localparam logic [3:0] IN_RAIL_A = 4'h1;
	localparam logic [3:0] IN_RAIL_B = 4'h2;
	localparam logic [3:0] IN_CTRL = 4'h5;
	// Fault latch split over two registers
	localparam int LATCH_LOW_W = 8;
	localparam int LATCH_HIGH_W = 2;
	// Timing
	localparam int CLK_MHZ = 125;
	localparam int TICK_US = 10;
	localparam int TICK_CYC = TICK_US * CLK_MHZ;
	localparam int LOAD_US = 20;
	localparam int LOAD_CYC = LOAD_US * CLK_MHZ;
	localparam int SEQ_MIN_US = 10;
	localparam int TMO_MIN_US = 100;
	localparam int DLY_MAX_MS = 400;
	localparam logic [15:0] SEQ_MIN_TK = 16'(SEQ_MIN_US / TICK_US);
	localparam logic [15:0] TMO_MIN_TK = 16'(TMO_MIN_US / TICK_US);
	localparam logic [15:0] DLY_MAX_TK = 16'(DLY_MAX_MS * 1000 / TICK_US);
	localparam logic [15:0] EX_TMO1_TK = 16'h03E8;
	localparam logic [15:0] EX_TMO2_TK = 16'h07D0;
	// Engine phase
	typedef enum logic [0:0] {
		PH_LOAD = 1'b0,
		PH_RUN = 1'b1
	} sqx_phase_t;
	// One state definition
	typedef struct packed {
		logic seq_en;
		logic [3:0] seq_sel;
		logic seq_pol;
		logic [15:0] seq_dly;
		logic [5:0] seq_next;
		logic [15:0] tmo_dly;
		logic [5:0] tmo_next;
		logic [N_SEL-1:0] mon_mask;
		logic [N_SEL-1:0] mon_exp;
		logic [5:0] mon_next;
		logic [N_OUT-1:0] outs;
		logic latch_en;
	} sqx_def_t;
	// Live status bundle
	typedef struct packed {
		logic [N_IN-1:0] uv;
		logic [N_IN-1:0] ov;
		logic limit;
	} sqx_stat_t;
endpackage

// ==== rtl/sqx_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for pin levels
module sqx_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// First stage feeds only the second
	logic [W-1:0] meta_reg;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/sqx_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
// Tick-based delay timer with restart
module sqx_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic restart,
	input wire logic [15:0] limit,
	output logic done
);
	typedef struct packed {
		logic [15:0] cnt;
	} sqx_tmr_t;
	sqx_tmr_t st_reg;
	sqx_tmr_t st_next;
	// Count ticks, saturate at limit
	always_comb begin
		st_next = st_reg;
		if (restart) begin
			st_next.cnt = '0;
		end else if (tick && st_reg.cnt < limit) begin
			st_next.cnt = st_reg.cnt + 16'h0001;
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	// Zero limit expires at once
	assign done = !restart && st_reg.cnt >= limit;
endmodule
`default_nettype wire

// ==== rtl/sqx_engine.sv ====
`timescale 1ns/100ps
`default_nettype none
// Supply sequencing state machine exit logic
module sqx_engine (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [sqx_pkg::N_IN-1:0] supply_ok,
	input wire logic [sqx_pkg::N_IN-1:0] warn_src,
	input wire sqx_pkg::sqx_stat_t stat_in,
	input wire logic jump_req,
	input wire logic fault_clr,
	input wire logic cfg_wr,
	input wire logic [5:0] cfg_addr,
	input wire sqx_pkg::sqx_def_t cfg_data,
	output logic [sqx_pkg::N_OUT-1:0] driver_output_pin,
	output logic [sqx_pkg::LATCH_LOW_W-1:0] fault_latch_low,
	output logic [sqx_pkg::LATCH_HIGH_W-1:0] fault_latch_high,
	output sqx_pkg::sqx_stat_t status,
	output logic [5:0] cur_state,
	output logic running
);
	// Whole engine state
	typedef struct packed {
		sqx_pkg::sqx_phase_t phase;
		logic [5:0] cur;
		sqx_pkg::sqx_def_t def;
		logic [11:0] load_cnt;
		logic [10:0] tick_cnt;
		logic entry;
		logic [sqx_pkg::N_OUT-1:0] outs;
		logic [sqx_pkg::N_IN-1:0] latch;
		sqx_pkg::sqx_stat_t stat;
	} sqx_eng_t;

	sqx_eng_t st_reg;
	sqx_eng_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic [sqx_pkg::N_IN-1:0] ok_s;
	logic [sqx_pkg::N_IN-1:0] warn_s;
	sqx_pkg::sqx_stat_t stat_s;
	logic [sqx_pkg::N_SEL-1:0] sel_in;
	logic [sqx_pkg::N_SEL-1:0] mon_bad;
	logic tick;
	logic seq_hit;
	logic seq_done;
	logic tmo_done;
	logic mon_fire;
	logic seq_fire;
	logic tmo_fire;
	logic run;
	logic jump_go;
	// State table, one word per state
	sqx_pkg::sqx_def_t mem [0:sqx_pkg::N_STATES-1];

	// Reset release through two flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Pin levels cross into core clock
	sqx_sync #(.W(sqx_pkg::N_IN)) u_ok (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(supply_ok),
		.q(ok_s)
	);
	sqx_sync #(.W(sqx_pkg::N_IN)) u_warn (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(warn_src),
		.q(warn_s)
	);
	sqx_sync #(.W($bits(sqx_pkg::sqx_stat_t))) u_stat (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.d(stat_in),
		.q(stat_s)
	);

	// Example program entry; other states idle
	function automatic sqx_pkg::sqx_def_t ex_def(input int i);
		sqx_pkg::sqx_def_t d;
		d = '0;
		d.seq_en = (i < 9);
		case (i)
			0: begin
				d.seq_sel = sqx_pkg::IN_CTRL;
				d.seq_next = 6'h01;
			end
			1: begin
				d.seq_sel = sqx_pkg::IN_MAIN;
				d.seq_pol = 1'b1;
				d.seq_next = 6'h02;
			end
			2: begin
				d.seq_sel = sqx_pkg::IN_RAIL_A;
				d.seq_pol = 1'b1;
				d.seq_next = 6'h04;
				d.tmo_dly = sqx_pkg::EX_TMO1_TK;
				d.tmo_next = 6'h03;
				d.mon_mask = 11'h001;
				d.mon_exp = 11'h001;
				d.outs = 10'h001;
			end
			3, 5: begin
				d.seq_sel = sqx_pkg::IN_CTRL;
				d.seq_pol = 1'b1;
				d.outs = (i == 3) ? 10'h006 : 10'h005;
			end
			4: begin
				d.seq_sel = sqx_pkg::IN_RAIL_B;
				d.seq_pol = 1'b1;
				d.seq_next = 6'h08;
				d.tmo_dly = sqx_pkg::EX_TMO2_TK;
				d.tmo_next = 6'h05;
				d.mon_mask = 11'h003;
				d.mon_exp = 11'h003;
				d.mon_next = 6'h07;
				d.outs = 10'h003;
			end
			6: begin
				d.seq_sel = sqx_pkg::IN_RAIL_B;
				d.seq_next = 6'h05;
				d.mon_mask = 11'h003;
				d.mon_exp = 11'h003;
				d.mon_next = 6'h07;
				d.outs = 10'h007;
			end
			7: begin
				d.seq_sel = sqx_pkg::IN_RAIL_A;
				d.seq_next = 6'h03;
				d.mon_mask = 11'h001;
				d.mon_exp = 11'h001;
				d.outs = 10'h007;
			end
			8: begin
				d.seq_sel = sqx_pkg::IN_CTRL;
				d.seq_pol = 1'b1;
				d.seq_next = 6'h05;
				d.mon_mask = 11'h007;
				d.mon_exp = 11'h007;
				d.mon_next = 6'h06;
				d.outs = 10'h003;
				d.latch_en = 1'b1;
			end
			default: begin
				d.seq_en = 1'b0;
			end
		endcase
		return d;
	endfunction

	// Table write port; any state may name any other
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < sqx_pkg::N_STATES; i++) begin
				mem[i] <= ex_def(i);
			end
		end else if (cfg_wr && cfg_addr < 6'(sqx_pkg::N_STATES)) begin
			mem[cfg_addr] <= cfg_data;
		end
	end

	// Warnings folded into one selectable input
	assign sel_in = {|warn_s, ok_s};
	assign run = st_reg.phase == sqx_pkg::PH_RUN;
	assign tick = st_reg.tick_cnt == 11'(sqx_pkg::TICK_CYC - 1);

	// Sequence input match and hold timer
	assign seq_hit = st_reg.def.seq_en && sel_in[st_reg.def.seq_sel] == st_reg.def.seq_pol;
	sqx_timer u_seq_tmr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick(tick),
		.restart(!run || st_reg.entry || !seq_hit),
		.limit(st_reg.def.seq_dly),
		.done(seq_done)
	);
	// Timeout runs from entry; zero means off
	sqx_timer u_tmo_tmr (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick(tick),
		.restart(!run || st_reg.entry),
		.limit(st_reg.def.tmo_dly),
		.done(tmo_done)
	);

	// Monitor: wide OR of deviations, no delay
	assign mon_bad = st_reg.def.mon_mask & (sel_in ^ st_reg.def.mon_exp);
	assign mon_fire = run && !st_reg.entry && |mon_bad;
	assign jump_go = run && jump_req;
	assign seq_fire = (run && !st_reg.entry && seq_hit && seq_done) || jump_go;
	assign tmo_fire = (run && !st_reg.entry && st_reg.def.tmo_dly != 16'h0000 && tmo_done) || jump_go;

	// Engine next state
	always_comb begin
		st_next = st_reg;
		st_next.entry = 1'b0;
		st_next.stat = stat_s;
		// Fixed tick base, restarted on entry
		if (tick || st_reg.entry) begin
			st_next.tick_cnt = '0;
		end else begin
			st_next.tick_cnt = st_reg.tick_cnt + 11'h001;
		end
		// Sticky fault bits; set beats clear
		if (fault_clr) begin
			st_next.latch = '0;
		end
		if (run && st_reg.def.latch_en) begin
			st_next.latch = st_next.latch | mon_bad[sqx_pkg::N_IN-1:0];
		end
		case (st_reg.phase)
			sqx_pkg::PH_LOAD: begin
				// Fetch definition before acting
				if (st_reg.load_cnt == 12'h001) begin
					st_next.phase = sqx_pkg::PH_RUN;
					st_next.def = mem[st_reg.cur];
					st_next.outs = mem[st_reg.cur].outs;
					st_next.entry = 1'b1;
				end else begin
					st_next.load_cnt = st_reg.load_cnt - 12'h001;
				end
			end
			sqx_pkg::PH_RUN: begin
				// Monitor first, then sequence, then timeout
				if (mon_fire) begin
					st_next.cur = st_reg.def.mon_next;
				end else if (seq_fire) begin
					st_next.cur = st_reg.def.seq_next;
				end else if (tmo_fire) begin
					st_next.cur = st_reg.def.tmo_next;
				end
				if (mon_fire || seq_fire || tmo_fire) begin
					st_next.phase = sqx_pkg::PH_LOAD;
					st_next.load_cnt = 12'(sqx_pkg::LOAD_CYC);
				end
			end
			default: begin
				st_next.phase = sqx_pkg::PH_LOAD;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{phase: sqx_pkg::PH_LOAD, load_cnt: 12'(sqx_pkg::LOAD_CYC), default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register
	assign driver_output_pin = st_reg.outs;
	assign fault_latch_low = st_reg.latch[sqx_pkg::LATCH_LOW_W-1:0];
	assign fault_latch_high = st_reg.latch[sqx_pkg::N_IN-1:sqx_pkg::LATCH_LOW_W];
	assign status = st_reg.stat;
	assign cur_state = st_reg.cur;
	assign running = run;

	// Checks
	a_jump_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
		jump_go && !mon_fire |=> st_reg.phase == sqx_pkg::PH_LOAD && st_reg.cur == $past(st_reg.def.seq_next))
		else $error("jump did not exit to sequence next");
	a_monitor_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
		mon_fire |=> st_reg.cur == $past(st_reg.def.mon_next))
		else $error("monitor exit lost priority");
	a_seq_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && !st_reg.entry && seq_hit && seq_done && !mon_fire |=> st_reg.cur == $past(st_reg.def.seq_next))
		else $error("sequence exit missed");
	a_tmo_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
		tmo_fire && !seq_fire && !mon_fire |=> st_reg.cur == $past(st_reg.def.tmo_next))
		else $error("timeout exit missed");
	a_load_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
		run ##1 !run |-> (!run)[*8])
		else $error("definition load too short");
	a_outs_held: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && !st_reg.entry && $past(run) |-> $stable(driver_output_pin))
		else $error("outputs changed inside a state");
	a_latch_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
		($past(st_reg.latch) & ~st_reg.latch) != '0 |-> $past(fault_clr))
		else $error("fault bit dropped without clear");
	a_latch_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		!(run && st_reg.def.latch_en) |=> (st_reg.latch & ~$past(st_reg.latch)) == '0)
		else $error("fault latched while disabled");
	a_seq_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && !seq_hit && !jump_go && !mon_fire |=> !seq_done || st_reg.def.seq_dly == 16'h0000)
		else $error("sequence timer not restarted");

	// A monitor deviation leaves the state on the very next edge
	a_monitor_fast: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && !st_reg.entry && |mon_bad |=> !run)
		else $error("monitor exit was delayed");

	// New pins appear together with the first running cycle
	a_entry_outs: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(run) |-> driver_output_pin == st_reg.def.outs)
		else $error("entry pins differ from definition");

	// Every deviation on the ten supply inputs seen while latching lands in the latch; the warning bit is not latched
	a_latch_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && st_reg.def.latch_en |=> (st_reg.latch & $past(mon_bad[sqx_pkg::N_IN-1:0])) == $past(mon_bad[sqx_pkg::N_IN-1:0]))
		else $error("fault bit not set");

	// Clear empties the latch when nothing can set it
	a_clear_works: assert property (@(posedge core_clk) disable iff (!rst_n)
		fault_clr && !(run && st_reg.def.latch_en) |=> st_reg.latch == '0)
		else $error("fault latch not cleared");

	// Status is a plain copy of the synced levels
	a_status_live: assert property (@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> status == $past(stat_s))
		else $error("status not live");

	// Zero timeout never exits unless a jump asks
	a_tmo_off: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && st_reg.def.tmo_dly == 16'h0000 && !jump_req |-> !tmo_fire)
		else $error("disabled timeout fired");

	// The entry cycle only settles timers, it never exits on its own
	a_entry_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && st_reg.entry && !jump_req |=> run)
		else $error("exit taken in entry cycle");

	// Every exit arms the full load count
	a_load_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(run) |-> st_reg.load_cnt == 12'(sqx_pkg::LOAD_CYC))
		else $error("load count not armed");

	// Without an exit the current state holds
	a_cur_steady: assert property (@(posedge core_clk) disable iff (!rst_n)
		run && !mon_fire && !seq_fire && !tmo_fire |=> st_reg.cur == $past(st_reg.cur))
		else $error("state moved without exit");
endmodule
`default_nettype wire

// ==== tb/sqx_supply_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Far side: supply comparators, warning sources, live status
module sqx_supply_model (
	input wire logic core_clk,
	input wire logic [9:0] want_ok,
	input wire logic [9:0] want_warn,
	input wire sqx_pkg::sqx_stat_t want_stat,
	output logic [9:0] supply_ok,
	output logic [9:0] warn_src,
	output sqx_pkg::sqx_stat_t stat_in
);
	// Known levels before the first edge
	initial begin
		supply_ok = 10'h000;
		warn_src = 10'h000;
		stat_in = '0;
	end
	// Comparators settle one clock after the rail moves, so no same-edge race
	always @(posedge core_clk) begin
		supply_ok <= want_ok;
		warn_src <= want_warn;
		stat_in <= want_stat;
	end
endmodule
`default_nettype wire

// ==== tb/tb_supply_sequencer_state_exit_logic.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_supply_sequencer_state_exit_logic;
	logic core_clk, rst_b, jump_req, fault_clr, cfg_wr, running;
	logic [5:0] cfg_addr, cur_state;
	logic [9:0] want_ok, want_warn, supply_ok, warn_src, driver_output_pin;
	logic [7:0] fault_latch_low;
	logic [1:0] fault_latch_high;
	sqx_pkg::sqx_def_t cfg_data;
	sqx_pkg::sqx_stat_t want_stat, stat_in, status;
	int err_total, checked, cyc_cnt, n;
	localparam int TK = sqx_pkg::TICK_CYC;
	localparam int LD = sqx_pkg::LOAD_CYC;

	sqx_engine u_dut (.core_clk(core_clk), .rst_b(rst_b), .supply_ok(supply_ok), .warn_src(warn_src),
		.stat_in(stat_in), .jump_req(jump_req), .fault_clr(fault_clr), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_data(cfg_data), .driver_output_pin(driver_output_pin), .fault_latch_low(fault_latch_low),
		.fault_latch_high(fault_latch_high), .status(status), .cur_state(cur_state), .running(running));
	sqx_supply_model u_sup (.core_clk(core_clk), .want_ok(want_ok), .want_warn(want_warn),
		.want_stat(want_stat), .supply_ok(supply_ok), .warn_src(warn_src), .stat_in(stat_in));

	// Free-running 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Hang guard, well above the expected run length
	always @(posedge core_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 60000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// Value compare, four-state exact
	task automatic chk_v(input string what, input logic [23:0] e, input logic [23:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	// Cycle count must land inside a window
	task automatic chk_in(input string what, input int lo, input int hi, input int g);
		checked++;
		if (g < lo || g > hi) begin
			err_total++;
			$display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, g);
		end
	endtask

	// Bounded wait for the active flag, counting cycles
	task automatic wait_run(input logic lvl, output int cnt);
		cnt = 0;
		while (running !== lvl && cnt < 20000) begin
			@(negedge core_clk);
			cnt++;
		end
	endtask

	// One definition per edge; strobe held high between writes
	task automatic wr(input logic [5:0] a, input sqx_pkg::sqx_def_t d);
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_data <= d;
	endtask

	task automatic jump();
		@(posedge core_clk);
		jump_req <= 1'b1;
		@(posedge core_clk);
		jump_req <= 1'b0;
	endtask

	function automatic sqx_pkg::sqx_def_t mk(input logic se, input logic [3:0] ss, input logic sp,
		input logic [15:0] sd, input logic [5:0] sn, input logic [15:0] td, input logic [5:0] tn,
		input logic [10:0] mm, input logic [10:0] me, input logic [5:0] mn, input logic [9:0] o, input logic le);
		mk = '{se, ss, sp, sd, sn, td, tn, mm, me, mn, o, le};
	endfunction

	// Outputs quiet in reset, first load then example idle outputs
	task automatic t_reset();
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk_v("pins in reset", 24'h0, {14'h0, driver_output_pin});
		chk_v("running in reset", 24'h0, {23'h0, running});
		@(posedge core_clk);
		rst_b <= 1'b1;
		wait_run(1'b1, n);
		chk_in("first load", LD, LD + 8, n);
		chk_v("idle pins", 24'h0, {14'h0, driver_output_pin});
	endtask

	// Private program in high states, reached through jumps
	task automatic t_setup();
		for (int a = 0; a < 9; a++) wr(6'(a), mk(0, 0, 0, 0, 20, 0, 0, 0, 0, 0, 10'h000, 0));
		wr(20, mk(1, sqx_pkg::IN_RAIL_A, 1, 2, 21, 8, 22, 0, 0, 0, 10'h001, 0));
		wr(21, mk(1, sqx_pkg::IN_RAIL_B, 1, 0, 25, 3, 23, 0, 0, 0, 10'h002, 0));
		wr(23, mk(1, sqx_pkg::IN_RAIL_A, 0, 0, 25, 0, 0, 11'h003, 11'h003, 24, 10'h155, 1));
		wr(24, mk(0, 0, 0, 0, 0, 0, 0, 11'h400, 11'h000, 26, 10'h2AA, 0));
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		jump();
		wait_run(1'b0, n);
		wait_run(1'b1, n);
		jump();
		wait_run(1'b0, n);
		chk_in("jump exit", 0, 2, n);
		wait_run(1'b1, n);
		chk_in("load time", LD - 5, LD + 5, n);
		chk_v("jump target", 24'd20, {18'h0, cur_state});
		chk_v("entry pins", 24'h001, {14'h0, driver_output_pin});
	endtask

	// Glitch in the delay window restarts the sequence timer
	task automatic t_seq();
		@(posedge core_clk);
		want_ok <= 10'h023;
		repeat (1400) @(posedge core_clk);
		want_ok <= 10'h021;
		repeat (10) @(posedge core_clk);
		want_ok <= 10'h023;
		@(negedge core_clk);
		chk_v("held during glitch", 24'h1, {23'h0, running});
		wait_run(1'b0, n);
		chk_in("sequence delay", TK, 2 * TK + 10, n);
		chk_v("sequence next", 24'd21, {18'h0, cur_state});
	endtask

	// Unmet sequence falls to the timeout exit
	task automatic t_tmo();
		wait_run(1'b1, n);
		wait_run(1'b0, n);
		chk_in("timeout delay", 2 * TK, 3 * TK + 10, n);
		chk_v("timeout next", 24'd23, {18'h0, cur_state});
	endtask

	// Monitor and sequence true together: monitor wins, fast
	task automatic t_mon();
		wait_run(1'b1, n);
		chk_v("state pins", 24'h155, {14'h0, driver_output_pin});
		@(posedge core_clk);
		want_ok <= 10'h021;
		wait_run(1'b0, n);
		chk_in("monitor latency", 0, 8, n);
		chk_v("monitor next", 24'd24, {18'h0, cur_state});
		chk_v("latch low", 24'h02, {16'h0, fault_latch_low});
	endtask

	// Sticky latch survives recovery, then warning exit
	task automatic t_latch();
		wait_run(1'b1, n);
		@(posedge core_clk);
		want_ok <= 10'h023;
		repeat (8) @(negedge core_clk);
		chk_v("latch kept", 24'h02, {16'h0, fault_latch_low});
		@(posedge core_clk);
		fault_clr <= 1'b1;
		@(posedge core_clk);
		fault_clr <= 1'b0;
		repeat (3) @(negedge core_clk);
		chk_v("latch cleared", 24'h0, {14'h0, fault_latch_high, fault_latch_low});
		@(posedge core_clk);
		want_warn <= 10'h008;
		wait_run(1'b0, n);
		chk_in("warning latency", 0, 8, n);
		chk_v("warning next", 24'd26, {18'h0, cur_state});
	endtask

	// Status follows the live levels both ways
	task automatic t_status();
		@(posedge core_clk);
		want_stat <= '{uv: 10'h003, ov: 10'h200, limit: 1'b1};
		repeat (6) @(negedge core_clk);
		chk_v("status set", {3'h0, 10'h003, 10'h200, 1'b1}, {3'h0, status});
		@(posedge core_clk);
		want_stat <= '0;
		repeat (6) @(negedge core_clk);
		chk_v("status clear", 24'h0, {3'h0, status});
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		jump_req = 1'b0;
		fault_clr = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 6'h00;
		cfg_data = '0;
		want_ok = 10'h021;
		want_warn = 10'h000;
		want_stat = '0;
		err_total = 0;
		checked = 0;
		cyc_cnt = 0;
		t_reset();
		t_setup();
		t_seq();
		t_tmo();
		t_mon();
		t_latch();
		t_status();
		give_verdict();
	end
endmodule
`default_nettype wire
